/* File: core/mpf_pkg.sv */
package mpf_pkg;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PWM_CONTROL_TWO = 8'h04;
   localparam logic [7:0] A_DEAD = 8'h08;
   localparam logic [7:0] A_DMAP = 8'h0C;
   localparam logic [7:0] A_FCTL = 8'h10;
   localparam logic [7:0] A_FSTAT = 8'h14;
   localparam logic [7:0] A_FCLR = 8'h18;
   localparam logic [7:0] A_MOUT = 8'h1C;
   localparam logic [7:0] A_MOD = 8'h20;
   localparam logic [7:0] A_VAL0 = 8'h24;
   localparam logic [7:0] A_CNT = 8'h3C;
   localparam logic [7:0] A_STEP = 8'h04;
   // ****************************************
   // Field positions and sizes
   // ****************************************
   localparam int C_EN = 0;
   localparam int C_LOAD_PERMISSION_BIT = 1;
   localparam int C_CTR = 2;
   localparam int C_CMP = 3;
   localparam int C_SWD = 4;
   localparam int CTRL_W = 5;
   localparam int P_PRS = 4;
   localparam logic [7:0] PWM_CONTROL_TWO_MASK = 8'h37;
   localparam logic [7:0] FCTL_MASK = 8'h33;
   localparam int F_AUT = 4;
   localparam int S_PIN = 4;
   localparam int M_OCTL = 6;
   localparam int CW = 12;
   localparam int NPWM = 6;
   localparam int NPAIR = 3;
   localparam int NFLT = 2;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [CW-1:0] RST_CNT = 12'h000;
   localparam logic [CW-1:0] CNT_ONE = 12'h001;
   localparam logic [2:0] DIV_ZERO = 3'h0;
   localparam logic [2:0] DIV_ONE = 3'h1;
endpackage : mpf_pkg

/* File: core/mpf_pwm_ctrl.sv */
// Behaviour
// - pair select bit picks even or odd value
// - buffered select and prescaler read back buffer
// - prescaler codes divide clock by 1,2,4,8
// - new prescaler applies at cycle start after load
// - nonzero prescaler waits one cycle after enable
// - write-once dead time in clock cycles
// - write-once disable map selects disabled pins
// - per fault pin automatic or manual handling
// - irq enable gates interrupt only, not disabling
// - fault flag set within two cycles of rise
// - status shows present fault pin level
// - write one clears flag, clear reads zero
// - manual levels replace generator, counter keeps running
// - clearing manual enable reconnects generator at once
// - manual complementary odd pin forced low while even partner high
// - center cycle twice modulus, edge cycle modulus
// - one counter tick per clock unprescaled
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mpf_pwm_ctrl (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [mpf_pkg::NFLT-1:0] fault_i,
   output logic [mpf_pkg::NPWM-1:0] pwm_o,
   output logic [mpf_pkg::NPWM-1:0] pwm_oe_n_o,
   output logic irq_o
);
   import mpf_pkg::*;

   // ****************************************
   // Bus slave
   // ****************************************
   logic wr_ff;
   logic [7:0] wa_ff;
   logic [31:0] rd_ff;
   logic acc;
   logic [31:0] rd_mux;

   assign acc = hsel_i & htrans_i[1] & hready_i & (haddr_i[31:8] == 24'h000000);
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = rd_ff;

   function automatic logic wr_en(input logic w, input logic [7:0] wa, input logic [7:0] a);
      wr_en = w & (wa == a);
   endfunction : wr_en
   function automatic logic [2:0] div_mask(input logic [1:0] p);
      div_mask = {p == 2'h3, p[1], p != 2'h0};
   endfunction : div_mask

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ff <= 1'b0;
         wa_ff <= RST_BYTE;
      end else begin
         wr_ff <= acc & hwrite_i;
         wa_ff <= haddr_i[7:0];
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   logic [CTRL_W-1:0] ctrl_ff;
   logic [7:0] pwm_control_two_ff, dead_ff, dmap_ff, fctl_ff;
   logic dead_lk_ff, dmap_lk_ff;
   logic [M_OCTL:0] mout_ff;
   logic [CW-1:0] mod_ff, mod_act_ff, cnt_ff;
   logic [CW-1:0] val_ff [NPWM];
   logic [CW-1:0] val_act_ff [NPWM];
   logic [NPAIR-1:0] sel_act_ff;
   logic [1:0] prs_act_ff;
   logic [NFLT-1:0] flag_ff, pin_q_ff, fdis_ff;
   logic load, cyc_end, tick;
   logic [NFLT-1:0] clr, rise;

   assign load = ctrl_ff[C_LOAD_PERMISSION_BIT] & (cyc_end | ~ctrl_ff[C_EN]);
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_ff <= '0;
      end else if (wr_en(wr_ff, wa_ff, A_CTRL)) begin
         ctrl_ff <= hwdata_i[CTRL_W-1:0];
      end else if (load) begin
         ctrl_ff[C_LOAD_PERMISSION_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwm_control_two_ff <= RST_BYTE;
         fctl_ff <= RST_BYTE;
         mout_ff <= '0;
         mod_ff <= RST_CNT;
      end else begin
         if (wr_en(wr_ff, wa_ff, A_PWM_CONTROL_TWO)) pwm_control_two_ff <= hwdata_i[7:0] & PWM_CONTROL_TWO_MASK;
         if (wr_en(wr_ff, wa_ff, A_FCTL)) fctl_ff <= hwdata_i[7:0] & FCTL_MASK;
         if (wr_en(wr_ff, wa_ff, A_MOUT)) mout_ff <= hwdata_i[M_OCTL:0];
         if (wr_en(wr_ff, wa_ff, A_MOD)) mod_ff <= hwdata_i[CW-1:0];
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dead_ff <= RST_BYTE;
         dead_lk_ff <= 1'b0;
      end else if (wr_en(wr_ff, wa_ff, A_DEAD) && !dead_lk_ff) begin
         dead_ff <= hwdata_i[7:0];
         dead_lk_ff <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dmap_ff <= RST_BYTE;
         dmap_lk_ff <= 1'b0;
      end else if (wr_en(wr_ff, wa_ff, A_DMAP) && !dmap_lk_ff) begin
         dmap_ff <= hwdata_i[7:0];
         dmap_lk_ff <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < NPWM; i++) val_ff[i] <= RST_CNT;
      end else begin
         for (int i = 0; i < NPWM; i++) begin
            if (wr_en(wr_ff, wa_ff, A_VAL0 + 8'(i) * A_STEP)) val_ff[i] <= hwdata_i[CW-1:0];
         end
      end
   end

   // Active copies: values, modulus and prescaler on load; select at each cycle end or while disabled
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mod_act_ff <= RST_CNT;
         prs_act_ff <= 2'h0;
         sel_act_ff <= '0;
         for (int i = 0; i < NPWM; i++) val_act_ff[i] <= RST_CNT;
      end else begin
         if (cyc_end | ~ctrl_ff[C_EN]) sel_act_ff <= pwm_control_two_ff[NPAIR-1:0];
         if (load) begin
            mod_act_ff <= mod_ff;
            prs_act_ff <= pwm_control_two_ff[P_PRS +: 2];
            for (int i = 0; i < NPWM; i++) val_act_ff[i] <= val_ff[i];
         end
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always_comb begin
      rd_mux = 32'h00000000;
      case (haddr_i[7:0])
         A_CTRL: rd_mux[CTRL_W-1:0] = ctrl_ff;
         A_PWM_CONTROL_TWO: rd_mux[7:0] = pwm_control_two_ff;
         A_DEAD: rd_mux[7:0] = dead_ff;
         A_DMAP: rd_mux[7:0] = dmap_ff;
         A_FCTL: rd_mux[7:0] = fctl_ff;
         A_FSTAT: rd_mux[7:0] = {2'h0, fault_i, 2'h0, flag_ff};
         A_FCLR: rd_mux = 32'h00000000;
         A_MOUT: rd_mux[M_OCTL:0] = mout_ff;
         A_MOD: rd_mux[CW-1:0] = mod_ff;
         A_CNT: rd_mux[CW-1:0] = cnt_ff;
         default: begin
            for (int i = 0; i < NPWM; i++) begin
               if (haddr_i[7:0] == A_VAL0 + 8'(i) * A_STEP) rd_mux[CW-1:0] = val_ff[i];
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) rd_ff <= 32'h00000000;
      else rd_ff <= (acc & ~hwrite_i) ? rd_mux : 32'h00000000;
   end

   // ****************************************
   // Prescaler and counter
   // ****************************************
   logic [2:0] div_ff;
   logic dn_ff, started_ff;

   assign tick = ctrl_ff[C_EN] & (div_ff == div_mask(prs_act_ff));
   assign cyc_end = tick & (ctrl_ff[C_CTR] ? (dn_ff & cnt_ff == CNT_ONE)
                                           : (cnt_ff == mod_act_ff - CNT_ONE));

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) div_ff <= DIV_ZERO;
      else if (tick | ~ctrl_ff[C_EN]) div_ff <= DIV_ZERO;
      else div_ff <= div_ff + DIV_ONE;
   end

   // Center counts 0 up to modulus and back; edge counts 0 to modulus-1
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_ff <= RST_CNT;
         dn_ff <= 1'b0;
      end else if (!ctrl_ff[C_EN]) begin
         cnt_ff <= RST_CNT;
         dn_ff <= 1'b0;
      end else if (tick) begin
         if (!ctrl_ff[C_CTR]) begin
            cnt_ff <= cyc_end ? RST_CNT : cnt_ff + CNT_ONE;
            dn_ff <= 1'b0;
         end else if (!dn_ff) begin
            cnt_ff <= cnt_ff + CNT_ONE;
            dn_ff <= (cnt_ff + CNT_ONE == mod_act_ff);
         end else begin
            cnt_ff <= cnt_ff - CNT_ONE;
            dn_ff <= !cyc_end;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) started_ff <= 1'b0;
      else if (!ctrl_ff[C_EN]) started_ff <= 1'b0;
      else if (prs_act_ff == 2'h0 || cyc_end) started_ff <= 1'b1;
   end

   // ****************************************
   // Faults and interrupt
   // ****************************************
   logic irq_ff;
   logic clr_ok, sw_dis_ff, dis_any;

   assign rise = fault_i & ~pin_q_ff;
   assign clr = {NFLT{wr_en(wr_ff, wa_ff, A_FCLR)}} & hwdata_i[NFLT-1:0];
   assign clr_ok = cyc_end | ~ctrl_ff[C_EN];
   assign dis_any = (|fdis_ff) | sw_dis_ff;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_q_ff <= '0;
         flag_ff <= '0;
      end else begin
         pin_q_ff <= fault_i;
         flag_ff <= (flag_ff & ~clr) | rise;
      end
   end

   // Auto faults release when pin is low, manual ones after flag clear; both wait for cycle end while running
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fdis_ff <= '0;
      end else begin
         for (int i = 0; i < NFLT; i++) begin
            if (fault_i[i]) fdis_ff[i] <= 1'b1;
            else if (clr_ok && (fctl_ff[F_AUT + i] || !flag_ff[i])) fdis_ff[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) sw_dis_ff <= 1'b0;
      else if (ctrl_ff[C_SWD]) sw_dis_ff <= 1'b1;
      else if (clr_ok) sw_dis_ff <= 1'b0;
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) irq_ff <= 1'b0;
      else irq_ff <= |(flag_ff & fctl_ff[NFLT-1:0]);
   end
   assign irq_o = irq_ff;
   // ****************************************
   // Output path
   // ****************************************
   logic [NPWM-1:0] pre, pwm_ff, oe_n_ff;
   logic [7:0] dt_ff [NPAIR];
   logic [NPAIR-1:0] top_q_ff;
   logic [NPAIR-1:0] top;
   logic octl, drive;

   assign octl = mout_ff[M_OCTL];
   assign drive = (ctrl_ff[C_EN] & started_ff) | octl;

   always_comb begin
      pre = '0;
      top = '0;
      for (int p = 0; p < NPAIR; p++) begin
         if (octl) top[p] = mout_ff[2*p];
         else if (sel_act_ff[p]) top[p] = cnt_ff < val_act_ff[2*p+1];
         else top[p] = cnt_ff < val_act_ff[2*p];
         if (!ctrl_ff[C_CMP]) begin
            pre[2*p] = octl ? mout_ff[2*p] : (cnt_ff < val_act_ff[2*p]);
            pre[2*p+1] = octl ? mout_ff[2*p+1] : (cnt_ff < val_act_ff[2*p+1]);
         end else if (dt_ff[p] == RST_BYTE && (top[p] == top_q_ff[p] || dead_ff == RST_BYTE)) begin
            pre[2*p] = top[p];
            pre[2*p+1] = octl ? (mout_ff[2*p+1] & ~top[p]) : ~top[p];
         end
      end
   end

   // Dead time covers the edge cycle itself and restarts on each edge of top
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         top_q_ff <= '0;
         for (int p = 0; p < NPAIR; p++) dt_ff[p] <= RST_BYTE;
      end else begin
         top_q_ff <= top;
         for (int p = 0; p < NPAIR; p++) begin
            if (top[p] != top_q_ff[p] && dead_ff != RST_BYTE) dt_ff[p] <= dead_ff - 8'h01;
            else if (dt_ff[p] != RST_BYTE) dt_ff[p] <= dt_ff[p] - 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwm_ff <= '0;
         oe_n_ff <= '1;
      end else begin
         pwm_ff <= drive ? (pre & ~({NPWM{dis_any}} & dmap_ff[NPWM-1:0])) : '0;
         oe_n_ff <= {NPWM{~drive}};
      end
   end
   assign pwm_o = pwm_ff;
   assign pwm_oe_n_o = oe_n_ff;
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_rise_a;
      fault_i[0] && !pin_q_ff[0];
   endsequence
   sequence s_clear_a;
      wr_en(wr_ff, wa_ff, A_FCLR) && hwdata_i[0] && !rise[0];
   endsequence
   a_flag_set: assert property (s_rise_a |-> ##[1:2] flag_ff[0])
      else $error("fault flag not set after rise");
   a_ack_clear: assert property (s_clear_a |=> !flag_ff[0])
      else $error("fault flag not cleared by ack");
   a_dead_lock: assert property (dead_lk_ff |=> $stable(dead_ff))
      else $error("dead time changed after first write");
   a_map_lock: assert property (dmap_lk_ff |=> $stable(dmap_ff))
      else $error("disable map changed after first write");
   a_presc_hold: assert property (!load |=> $stable(prs_act_ff))
      else $error("prescaler applied without load");
   a_start_wait: assert property (ctrl_ff[C_EN] && !started_ff && !octl |=> &pwm_oe_n_o)
      else $error("pins driven before first cycle");
   a_tick_full: assert property (ctrl_ff[C_EN] && prs_act_ff == 2'h0 |-> tick)
      else $error("missing tick without prescaler");
   a_tick_div8: assert property (disable iff (!reset_n_i || !ctrl_ff[C_EN])
      tick && prs_act_ff == 2'h3 && !load |=> !tick [*7] ##1 tick)
      else $error("divide by eight wrong");
   a_manual_pin: assert property (octl && !ctrl_ff[C_CMP] && !dis_any |=> pwm_o[0] == $past(mout_ff[0]))
      else $error("manual level not on pin");
   a_fault_gate: assert property (dis_any && dmap_ff[0] |=> !pwm_o[0])
      else $error("mapped pin not disabled");
   a_irq_mask: assert property (!(|(flag_ff & fctl_ff[NFLT-1:0])) |=> !irq_o)
      else $error("interrupt without enabled flag");
endmodule : mpf_pwm_ctrl
`default_nettype wire

/* File: sim/mpf_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Power stage and fault sensors
// ****************************************
module mpf_stage_model (
   input wire logic sys_clk_i,
   input wire logic [mpf_pkg::NFLT-1:0] fault_req_i,
   input wire logic [mpf_pkg::NPWM-1:0] pwm_i,
   input wire logic [mpf_pkg::NPWM-1:0] pwm_oe_n_i,
   output logic [mpf_pkg::NFLT-1:0] fault_o,
   output logic [mpf_pkg::NPWM-1:0] pin_o
);
   import mpf_pkg::*;
   logic [NPWM-1:0] last_ff = '0;
   // Sensor levels arrive already synchronous
   assign fault_o = fault_req_i;
   // Remember the level each pin was last driven to
   always @(posedge sys_clk_i) begin
      for (int k = 0; k < NPWM; k++) begin
         if (!pwm_oe_n_i[k]) last_ff[k] <= pwm_i[k];
      end
   end
   // Released pins settle to the inverse of the last driven level
   always_comb begin
      for (int k = 0; k < NPWM; k++) begin
         pin_o[k] = pwm_oe_n_i[k] ? ~last_ff[k] : pwm_i[k];
      end
   end
endmodule : mpf_stage_model
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mpf_pkg::*;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] fault_req = 2'h0;
   logic [31:0] hrdata_o;
   logic hreadyout_o;
   logic irq_o;
   logic hresp;
   logic prev0 = 1'b0;
   logic [NPWM-1:0] pwm_o, pwm_oe_n_o, pin;
   logic [NFLT-1:0] fault;
   logic [31:0] v, m, seed;
   int err_total = 0, comparisons = 0, cyc = 0, since = 0, last_per = 0;
   mpf_pwm_ctrl dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp), .fault_i(fault), .pwm_o(pwm_o),
      .pwm_oe_n_o(pwm_oe_n_o), .irq_o(irq_o));
   mpf_stage_model stage (.sys_clk_i(sys_clk_i), .fault_req_i(fault_req), .pwm_i(pwm_o),
      .pwm_oe_n_i(pwm_oe_n_o), .fault_o(fault), .pin_o(pin));
   initial begin
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge sys_clk_i);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
      r = hrdata_o;
      chk("response", 32'h0, {31'h0, hresp});
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk(n, e, r);
   endtask : rd
   function automatic logic [5:0] man_exp(input logic [5:0] l, input logic comp);
      man_exp = l;
      for (int k = 0; k < 6; k += 2) begin
         if (comp) man_exp[k+1] = l[k+1] & ~l[k];
      end
   endfunction : man_exp
   // Cycle watchdog and period of the first pin
   always @(posedge sys_clk_i) begin
      cyc++;
      since++;
      if (pwm_o[0] === 1'b1 && prev0 === 1'b0) begin
         last_per = since;
         since = 0;
      end
      prev0 = pwm_o[0];
      if (cyc == 40000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      seed = $urandom(32'h9CA8);
      repeat (16) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0, "reset value");
      wr(8'h80, $urandom);
      rd(8'h80, 32'h0, "unmapped");
      for (int i = 0; i < 4; i++) begin
         v = ($urandom & 32'h7) | 32'(i << P_PRS);
         wr(A_PWM_CONTROL_TWO, v);
         rd(A_PWM_CONTROL_TWO, v, "select and divider");
      end
      wr(A_DEAD, 32'h3);
      wr(A_DEAD, 32'h80 | $urandom);
      rd(A_DEAD, 32'h3, "dead time");
      wr(A_DMAP, 32'h3F);
      wr(A_DMAP, 32'h0);
      rd(A_DMAP, 32'h3F, "disable map");
      v = $urandom;
      wr(A_FCTL, v);
      rd(A_FCTL, v & 32'(FCTL_MASK), "fault control");
      wr(A_FCTL, 32'h0);
      wr(A_MOUT, 32'h7F);
      repeat (3) @(posedge sys_clk_i);
      chk("manual pins", 32'h3F, 32'(pin));
      fault_req <= 2'h1;
      repeat (3) @(posedge sys_clk_i);
      chk("fault a pins irq", 32'h0, {25'h0, irq_o, pin});
      rd(A_FSTAT, 32'h11, "status a");
      fault_req <= 2'h0;
      wr(A_FCLR, 32'h0);
      rd(A_FSTAT, 32'h01, "flag kept");
      chk("manual fault holds", 32'h0, 32'(pin));
      wr(A_FCLR, 32'h1);
      rd(A_FCLR, 32'h0, "clear reads zero");
      rd(A_FSTAT, 32'h0, "flag cleared");
      repeat (3) @(posedge sys_clk_i);
      chk("pins back", 32'h3F, 32'(pin));
      wr(A_FCTL, 32'h22);
      fault_req <= 2'h2;
      repeat (3) @(posedge sys_clk_i);
      chk("fault b pins irq", 32'h40, {25'h0, irq_o, pin});
      rd(A_FSTAT, 32'h22, "status b");
      fault_req <= 2'h0;
      repeat (4) @(posedge sys_clk_i);
      chk("auto release", 32'h7F, {25'h0, irq_o, pin});
      wr(A_FCLR, 32'h2);
      repeat (3) @(posedge sys_clk_i);
      chk("irq cleared", 32'h3F, {25'h0, irq_o, pin});
      wr(A_CTRL, 32'h1 << C_SWD);
      repeat (3) @(posedge sys_clk_i);
      chk("software disable", 32'h0, 32'(pin));
      for (int i = 0; i < 6; i++) begin
         v = $urandom & 32'h3F;
         wr(A_CTRL, 32'(i < 4) << C_CMP);
         wr(A_MOUT, 32'h40 | v);
         repeat (8) @(posedge sys_clk_i);
         chk("manual levels", 32'(man_exp(v[5:0], i < 4)), 32'(pin));
      end
      wr(A_CTRL, 32'h0);
      wr(A_MOUT, 32'h0);
      repeat (2) @(posedge sys_clk_i);
      chk("released at once", 32'h3F, 32'(pwm_oe_n_o));
      for (int i = 0; i < 8; i++) begin
         m = 4 + $urandom % 13;
         wr(A_MOD, m);
         wr(A_VAL0, m >> 1);
         wr(A_PWM_CONTROL_TWO, 32'((i % 4) << P_PRS));
         wr(A_CTRL, (32'(i / 4) << C_CTR) | (32'h1 << C_LOAD_PERMISSION_BIT));
         wr(A_CTRL, (32'(i / 4) << C_CTR) | 32'h1);
         repeat (3) @(posedge sys_clk_i);
         chk("start delay", (i % 4 == 0) ? 32'h0 : 32'h3F, 32'(pwm_oe_n_o));
         v = (m << (i / 4)) << (i % 4);
         repeat (3 * v + 8) @(posedge sys_clk_i);
         chk("pwm cycle", v, 32'(last_per));
         wr(A_CTRL, 32'h0);
      end
      wr(A_MOD, 32'h8);
      wr(A_VAL0, 32'h0);
      wr(A_VAL0 + A_STEP, 32'h8);
      for (int i = 0; i < 2; i++) begin
         wr(A_PWM_CONTROL_TWO, 32'(1 - i));
         wr(A_CTRL, (32'h1 << C_CMP) | (32'h1 << C_LOAD_PERMISSION_BIT));
         wr(A_CTRL, (32'h1 << C_CMP) | 32'h1);
         repeat (24) @(posedge sys_clk_i);
         chk("pair a select", 32'(1 - i), 32'(pwm_o[0]));
         wr(A_CTRL, 32'h0);
      end
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
